// [rtl/exposure_readout_sequencer.sv]
// Notes on behaviour
// (R01) each acquisition is exposure first, then sensor readout after exposure ends
// (R02) non-overlapped: exposure and readout of one image finish before next starts
// (R03) normal variant accepts a new exposure while prior readout still runs
// (R04) overlap is not a setting; it follows from trigger spacing only
// (R05) trigger source must not start exposure during a running exposure
// (R06) trigger source must not end exposure before prior readout completes
// (R07) triggers breaking either overlap condition are discarded unacted
// (R08) restricted variant: exposure waits until previous readout fully completes
// (R09) restricted variant: longer exposure lowers the highest reachable frame rate
// (R10) readiness output shows when a hardware trigger may start next acquisition
// (R11) exposure-active output high at exposure start, low at exposure end
// (R12) exposure-active edges lag the real exposure edges by a fixed delay
// (R13) exposure-active routed to line 1 after reset; routing reconfigurable
// (R14) routing is select line first, then write that line's source
// (R15) readiness high when safe, low at acquisition start, high again when safe
// (R16) acquisition start attempts while readiness is low are ignored
// (R17) separate exposing and reading flags decide trigger acceptance; normal variant checks the remaining readout count, not the reading flag
`timescale 1ns/1ps
`include "exposure_readout_defines.svh"
`default_nettype none

module exposure_readout_sequencer
    import exposure_readout_pkg::*;
#(
    parameter int CNT_W = `SEQ_CNT_W,
    parameter int NUM_LINES = `SEQ_NUM_LINES,
    parameter int SEL_W = `SEQ_SEL_W,
    parameter int DLY_CYC = `SEQ_EXPOSURE_ACTIVE_OUT_DLY_CYC
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic trigger_in,
    input wire logic restricted_in,
    input wire logic [CNT_W-1:0] exp_time_in,
    input wire logic [CNT_W-1:0] readout_time_in,
    input wire logic line_sel_wr_in,
    input wire logic [SEL_W-1:0] line_sel_in,
    input wire logic line_src_wr_in,
    input wire line_src_t line_src_in,
    output logic exposure_active_out,
    output logic trigger_safe_out,
    output logic trigger_dropped_out,
    output seq_status_t status_out,
    output logic [NUM_LINES-1:0] line_out
);

    // ************************************************
    // phase counters
    // ************************************************
    logic [CNT_W-1:0] exp_cnt_r;
    logic [CNT_W-1:0] exp_cnt_nxt;
    logic [CNT_W-1:0] rd_cnt_r;
    logic [CNT_W-1:0] rd_cnt_nxt;
    logic exp_busy;
    logic rd_busy;
    logic exp_end;
    logic safe;
    logic accept;

    assign exp_busy = (exp_cnt_r != '0); // [R17]
    assign rd_busy = (rd_cnt_r != '0); // [R17]
    assign exp_end = (exp_cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});

    // readout left must not outlast the new exposure
    always_comb begin
        safe = 1'b0;
        if (!exp_busy && (exp_time_in != '0)) begin // [R05] [R07]
            if (restricted_in) begin
                safe = !rd_busy; // [R08] [R09] [R02]
            end else begin
                safe = (rd_cnt_r <= exp_time_in); // [R03] [R06] [R07]
            end
        end
    end

    assign accept = trigger_in && safe; // [R16]
    assign trigger_safe_out = safe; // [R10] [R15]

    always_comb begin
        exp_cnt_nxt = exp_cnt_r;
        if (accept) begin
            exp_cnt_nxt = exp_time_in; // [R11]
        end else if (exp_busy) begin
            exp_cnt_nxt = exp_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // readout only ever begins in the cycle after the exposure's last cycle
    always_comb begin
        rd_cnt_nxt = rd_cnt_r;
        if (exp_end) begin
            rd_cnt_nxt = readout_time_in; // [R01]
        end else if (rd_busy) begin
            rd_cnt_nxt = rd_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            exp_cnt_r <= '0;
            rd_cnt_r <= '0;
        end else begin
            exp_cnt_r <= exp_cnt_nxt;
            rd_cnt_r <= rd_cnt_nxt;
        end
    end

    // ************************************************
    // status and discard flag
    // ************************************************
    seq_status_t status_r;
    seq_status_t status_nxt;
    logic drop_r;
    logic drop_nxt;

    always_comb begin
        status_nxt = status_r;
        status_nxt.exposing = (exp_cnt_nxt != '0);
        status_nxt.reading = (rd_cnt_nxt != '0);
        if (accept) begin
            status_nxt.overlapped = rd_busy; // [R04]
        end
        drop_nxt = trigger_in && !safe; // [R07] [R16]
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_r <= '0;
            drop_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            drop_r <= drop_nxt;
        end
    end

    assign status_out = status_r;
    assign trigger_dropped_out = drop_r;

    // ************************************************
    // exposure-active delay line
    // ************************************************
    // needs DLY_CYC of at least 2
    logic [DLY_CYC-1:0] dly_r;
    logic [DLY_CYC-1:0] dly_nxt;

    always_comb begin
        dly_nxt = {dly_r[DLY_CYC-2:0], exp_busy}; // [R11] [R12]
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dly_r <= '0;
        end else begin
            dly_r <= dly_nxt;
        end
    end

    assign exposure_active_out = dly_r[DLY_CYC-1];

    // ************************************************
    // output line routing
    // ************************************************
    function automatic logic line_drive(input line_src_t src, input logic ea, input logic ts);
        logic v;
        v = 1'b0;
        unique case (src)
            SRC_OFF: v = 1'b0;
            SRC_EXPOSURE_ACTIVE: v = ea;
            SRC_TRIGGER_SAFE: v = ts;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : line_drive

    logic [SEL_W-1:0] sel_r;
    logic [SEL_W-1:0] sel_nxt;
    line_src_t src_r [NUM_LINES];
    line_src_t src_nxt [NUM_LINES];
    logic [NUM_LINES-1:0] line_r;
    logic [NUM_LINES-1:0] line_nxt;

    always_comb begin
        sel_nxt = sel_r;
        if (line_sel_wr_in) begin
            sel_nxt = line_sel_in; // [R14]
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_r <= '0;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    generate
        for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
            // source write lands on the line chosen earlier
            always_comb begin
                src_nxt[i] = src_r[i];
                if (line_src_wr_in && (sel_r == SEL_W'(i))) begin
                    src_nxt[i] = line_src_in; // [R13] [R14]
                end
                line_nxt[i] = line_drive(src_r[i], exposure_active_out, safe);
            end

            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    if (i == `SEQ_EXPOSURE_ACTIVE_OUT_LINE) begin
                        src_r[i] <= SRC_EXPOSURE_ACTIVE; // [R13]
                    end else if (i == `SEQ_SAFE_LINE) begin
                        src_r[i] <= SRC_TRIGGER_SAFE;
                    end else begin
                        src_r[i] <= SRC_OFF;
                    end
                    line_r[i] <= 1'b0;
                end else begin
                    src_r[i] <= src_nxt[i];
                    line_r[i] <= line_nxt[i];
                end
            end
        end
    endgenerate

    assign line_out = line_r;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    a_exp_no_restart: assert property (exp_busy |-> !accept) // [R05] [R07]
        else $error("trigger accepted during exposure");

    a_exp_loads_time: assert property (accept |=> exp_cnt_r == $past(exp_time_in)) // [R11]
        else $error("exposure length not taken from setting");

    a_readout_after_exp: assert property (exp_end |=> rd_cnt_r == $past(readout_time_in)) // [R01]
        else $error("readout did not follow exposure end");

    a_exp_end_order: assert property (exp_end |-> rd_cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) // [R06] [R07]
        else $error("exposure ended before prior readout");

    a_restrict_serial: assert property (restricted_in && accept |-> !rd_busy) // [R08] [R02]
        else $error("restricted exposure overlapped readout");

    a_exposure_active_out_lag: assert property ($rose(exp_busy) |-> ##DLY_CYC $rose(exposure_active_out)) // [R12]
        else $error("exposure active rise lag wrong");

    a_exposure_active_out_fall_lag: assert property ($fell(exp_busy) |-> ##DLY_CYC $fell(exposure_active_out)) // [R11] [R12]
        else $error("exposure active fall lag wrong");

    a_safe_falls: assert property (accept |=> !trigger_safe_out) // [R15]
        else $error("readiness stayed high after start");

    a_drop_flag: assert property (trigger_in && !trigger_safe_out |=> trigger_dropped_out && !$rose(exp_busy)) // [R16]
        else $error("ignored trigger not flagged or acted on");

    a_overlap_flag: assert property (accept && rd_busy |=> status_out.overlapped) // [R04] [R03]
        else $error("overlap not reported");

    a_line_route: assert property (src_r[0] == SRC_EXPOSURE_ACTIVE |=> line_out[0] == $past(exposure_active_out)) // [R13]
        else $error("line 1 not following exposure active");

    // a zero exposure length would start nothing, so the gate stays shut
    a_safe_time_zero: assert property (exp_time_in == '0 |-> !trigger_safe_out) // [R10]
        else $error("readiness high with zero exposure length");

    a_rd_start_source: assert property ($rose(rd_busy) |-> $past(exp_end)) // [R01]
        else $error("readout began without an exposure end");

    a_exposure_active_out_follow: assert property (exposure_active_out == $past(exp_busy, DLY_CYC)) // [R11] [R12]
        else $error("exposure active not a delayed copy of exposure");

    a_drop_quiet: assert property (!trigger_in |=> !trigger_dropped_out) // [R07]
        else $error("discard flagged without a trigger");

    a_status_flags: assert property (status_out.exposing == exp_busy && status_out.reading == rd_busy) // [R17]
        else $error("status flags disagree with phase counters");

    a_restrict_no_ovl: assert property (restricted_in && accept |=> !status_out.overlapped) // [R08]
        else $error("restricted start reported as overlapped");

    a_safe_returns: assert property (!exp_busy && !rd_busy && exp_time_in != '0 |-> trigger_safe_out) // [R15] [R10]
        else $error("readiness low while sequencer idle");

    a_src_select_wr: assert property (line_src_wr_in && (sel_r == '0) |=> src_r[0] == $past(line_src_in)) // [R14]
        else $error("source write missed the selected line");

    // ************************************************
    // scenario covers
    // ************************************************
    c_overlap_start: cover property (accept && rd_busy && !restricted_in);
    c_restricted_start: cover property (accept && restricted_in);
    c_dropped: cover property (trigger_in && exp_busy);
    c_reroute: cover property (line_sel_wr_in ##1 line_src_wr_in);
    c_restricted_wait: cover property (restricted_in && trigger_in && rd_busy);

endmodule : exposure_readout_sequencer

`default_nettype wire

// [rtl/exposure_readout_defines.svh]
`ifndef EXPOSURE_READOUT_DEFINES_SVH
`define EXPOSURE_READOUT_DEFINES_SVH

// ************************************************
// timing
// ************************************************
`define SEQ_CLK_PERIOD_NS 5
// exposure-active output lag behind the exposure phase
`define SEQ_EXPOSURE_ACTIVE_OUT_DLY_NS 20
`define SEQ_EXPOSURE_ACTIVE_OUT_DLY_CYC ((`SEQ_EXPOSURE_ACTIVE_OUT_DLY_NS + `SEQ_CLK_PERIOD_NS - 1) / `SEQ_CLK_PERIOD_NS)

// ************************************************
// sizes and reset routing
// ************************************************
`define SEQ_CNT_W 20
`define SEQ_NUM_LINES 2
`define SEQ_SEL_W 1
// physical line 1 is index 0, line 2 is index 1
`define SEQ_EXPOSURE_ACTIVE_OUT_LINE 0
`define SEQ_SAFE_LINE 1

`endif

// [rtl/exposure_readout_pkg.sv]
package exposure_readout_pkg;

    // ************************************************
    // output line sources
    // ************************************************
    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_EXPOSURE_ACTIVE,
        SRC_TRIGGER_SAFE
    } line_src_t;

    // ************************************************
    // sequencer status
    // ************************************************
    typedef struct packed {
        logic exposing;
        logic reading;
        logic overlapped;
    } seq_status_t;

endpackage : exposure_readout_pkg

// [dv/trigger_source_model.sv]
`timescale 1ns/1ps
`default_nettype none

module trigger_source_model (
    input wire logic safe_in,
    input wire logic go_in,
    input wire logic force_in,
    output logic trig_out
);
    // ****************
    // trigger pacing
    // ****************
    // waits on the readiness level; force_in breaks the spacing on purpose
    assign trig_out = go_in & (safe_in | force_in);
endmodule : trigger_source_model

`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`include "exposure_readout_defines.svh"
`default_nettype none

module tb
    import exposure_readout_pkg::*;
;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic go = 1'b0;
    logic frc = 1'b0;
    logic trigger_in;
    logic restricted_in = 1'b0;
    logic [`SEQ_CNT_W-1:0] exp_time_in = 20'h00002;
    logic [`SEQ_CNT_W-1:0] readout_time_in = 20'h00003;
    logic line_sel_wr_in = 1'b0;
    logic [0:0] line_sel_in = 1'h0;
    logic line_src_wr_in = 1'b0;
    line_src_t line_src_in = SRC_OFF;
    logic exposure_active_out;
    logic trigger_safe_out;
    logic trigger_dropped_out;
    seq_status_t status_out;
    logic [1:0] line_out;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2.5 mclk_in = ~mclk_in;

    exposure_readout_sequencer i_exposure_readout_sequencer (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .trigger_in(trigger_in),
        .restricted_in(restricted_in),
        .exp_time_in(exp_time_in),
        .readout_time_in(readout_time_in),
        .line_sel_wr_in(line_sel_wr_in),
        .line_sel_in(line_sel_in),
        .line_src_wr_in(line_src_wr_in),
        .line_src_in(line_src_in),
        .exposure_active_out(exposure_active_out),
        .trigger_safe_out(trigger_safe_out),
        .trigger_dropped_out(trigger_dropped_out),
        .status_out(status_out),
        .line_out(line_out)
    );

    trigger_source_model i_trigger_source_model (
        .safe_in(trigger_safe_out),
        .go_in(go),
        .force_in(frc),
        .trig_out(trigger_in)
    );

    // ****************
    // helpers
    // ****************
    task chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: output level differs", $time);
        end
    endtask : chk

    task summarize;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // one attempt; returns in the cycle after the taking edge
    task fire(input logic f);
        @(negedge mclk_in);
        go = 1'b1;
        frc = f;
        @(negedge mclk_in);
        go = 1'b0;
        frc = 1'b0;
    endtask : fire

    task settle;
        for (int i = 0; i < 200 && status_out[2:1] !== 2'b00; i++) begin
            @(negedge mclk_in);
        end
        @(negedge mclk_in);
    endtask : settle

    // ****************
    // scenarios
    // ****************
    task t_reset;
        @(negedge mclk_in);
        chk(exposure_active_out, 1'b0);
        chk(line_out[0], 1'b0);
        chk(trigger_safe_out, 1'b1);
    endtask : t_reset

    task t_route_walk;
        @(negedge mclk_in);
        line_sel_wr_in = 1'b1;
        line_sel_in = 1'h1;
        @(negedge mclk_in);
        line_sel_wr_in = 1'b0;
        line_src_wr_in = 1'b1;
        line_src_in = SRC_EXPOSURE_ACTIVE;
        @(negedge mclk_in);
        line_src_wr_in = 1'b0;
        fire(1'b0);
        for (int c = 1; c <= 8; c++) begin
            chk(status_out.exposing, c <= 2);
            chk(status_out.reading, c > 2 && c <= 5);
            if (c <= 2) chk(trigger_safe_out, 1'b0);
            chk(exposure_active_out, c >= 5 && c <= 6);
            chk(line_out[0], c >= 6 && c <= 7);
            chk(line_out[1], c >= 6 && c <= 7);
            @(negedge mclk_in);
        end
    endtask : t_route_walk

    task t_drop;
        exp_time_in = 20'h00006;
        readout_time_in = 20'h00001;
        fire(1'b0);
        fire(1'b1);
        chk(trigger_dropped_out, 1'b1);
        @(negedge mclk_in);
        chk(trigger_dropped_out, 1'b0);
        repeat (3) @(negedge mclk_in);
        chk(status_out.exposing, 1'b0);
    endtask : t_drop

    // second trigger right after the first exposure ends
    task t_overlap(input logic [`SEQ_CNT_W-1:0] e, input logic [`SEQ_CNT_W-1:0] r, input logic restr,
                   input logic ok);
        settle;
        restricted_in = restr;
        exp_time_in = e;
        readout_time_in = r;
        fire(1'b0);
        repeat (e) @(negedge mclk_in);
        chk(status_out.reading, 1'b1);
        chk(trigger_safe_out, ok);
        fire(1'b1);
        chk(trigger_dropped_out, !ok);
        chk(status_out.exposing, ok);
        chk(status_out.overlapped, ok);
        if (restr) begin
            repeat (r - 3) @(negedge mclk_in);
            chk(trigger_safe_out, 1'b0);
            @(negedge mclk_in);
            chk(trigger_safe_out, 1'b1);
        end
    endtask : t_overlap

    // line 1 carries readiness, line 2 switched off
    task t_route_alt;
        settle;
        restricted_in = 1'b0;
        exp_time_in = 20'h00003;
        readout_time_in = 20'h00002;
        line_sel_wr_in = 1'b1;
        line_sel_in = 1'h0;
        @(negedge mclk_in);
        line_sel_wr_in = 1'b0;
        line_src_wr_in = 1'b1;
        line_src_in = SRC_TRIGGER_SAFE;
        @(negedge mclk_in);
        line_src_wr_in = 1'b0;
        line_sel_wr_in = 1'b1;
        line_sel_in = 1'h1;
        @(negedge mclk_in);
        line_sel_wr_in = 1'b0;
        line_src_wr_in = 1'b1;
        line_src_in = SRC_OFF;
        @(negedge mclk_in);
        line_src_wr_in = 1'b0;
        chk(line_out[0], 1'b1);
        fire(1'b0);
        chk(line_out[0], 1'b1);
        @(negedge mclk_in);
        chk(line_out[0], 1'b0);
        repeat (3) @(negedge mclk_in);
        chk(line_out[0], 1'b1);
        @(negedge mclk_in);
        chk(exposure_active_out, 1'b1);
        chk(line_out[1], 1'b0);
    endtask : t_route_alt

    // zero exposure length never opens the gate
    task t_zero_time;
        settle;
        exp_time_in = 20'h00000;
        fire(1'b1);
        chk(trigger_safe_out, 1'b0);
        chk(trigger_dropped_out, 1'b1);
        chk(status_out.exposing, 1'b0);
        exp_time_in = 20'h00002;
    endtask : t_zero_time

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            summarize;
        end
    end

    initial begin
        repeat (20) @(negedge mclk_in);
        rstn_in = 1'b1;
        t_reset;
        t_route_walk;
        settle;
        t_drop;
        t_overlap(20'h0000a, 20'h00005, 1'b0, 1'b1);
        t_overlap(20'h00002, 20'h00008, 1'b0, 1'b0);
        t_overlap(20'h0000a, 20'h00005, 1'b1, 1'b0);
        t_route_alt;
        t_zero_time;
        settle;
        summarize;
    end
endmodule : tb

`default_nettype wire
